// file: rtl/pse_defines.svh
// pse_defines.svh: constants for the port strobe and external memory cycle block
// assumes one 20 MHz clock that stands in for the cpu clock output timebase
`ifndef PSE_DEFINES_SVH
`define PSE_DEFINES_SVH
`define PSE_STROBE_CYCLES   3'h2
`define PSE_WR_DELAY_CYCLES 3'h2
`define PSE_RD_DELAY_CYCLES 3'h3
`define PSE_PMEM_WINDOW     3'h3
`define PSE_DMEM_SHORT      3'h3
`define PSE_DMEM_LONG       3'h5
`define PSE_PORT_RESET      8'h00
`define PSE_ADDR_RESET      16'h0000
`endif

// file: rtl/pse_pkg.sv
// pse_pkg.sv: types shared by the port strobe block
// assumes nothing beyond the defines header
`default_nettype none
package pse_pkg;
	typedef enum logic [1:0] {PSE_IDLE, PSE_DELAY, PSE_PULSE} pse_state_type;
	typedef enum logic [1:0] {PSE_MEM_IDLE, PSE_MEM_ACTIVE} pse_mem_type;
endpackage : pse_pkg
`default_nettype wire

// file: rtl/pse_pulse.sv
// pse_pulse.sv: delayed fixed-length strobe pulse generator
// assumes a one-cycle trigger; a new trigger while busy restarts the sequence
`include "pse_defines.svh"
`default_nettype none
module pse_pulse #(
	parameter int DELAY_W = 3
) (
	input  wire logic               clk,     // clock
	input  wire logic               rst_n,   // async reset, active low
	input  wire logic               trigger, // start pulse
	input  wire logic [DELAY_W-1:0] delay,   // cycles before the pulse
	input  wire logic [DELAY_W-1:0] width,   // cycles of the pulse
	output logic                    active   // pulse level, active high
);
	pse_pkg::pse_state_type state;
	logic [DELAY_W-1:0]     count;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state  <= pse_pkg::PSE_IDLE;
			count  <= '0;
			active <= 1'b0;
		end else if (trigger) begin
			state  <= pse_pkg::PSE_DELAY;
			count  <= delay - 3'h1;
			active <= 1'b0;
		end else begin
			case (state)
				pse_pkg::PSE_DELAY: begin
					if (count == '0) begin
						state  <= pse_pkg::PSE_PULSE;
						count  <= width - 3'h1;
						active <= 1'b1;
					end else begin
						count <= count - 3'h1;
					end
				end
				pse_pkg::PSE_PULSE: begin
					if (count == '0) begin
						state  <= pse_pkg::PSE_IDLE;
						active <= 1'b0;
					end else begin
						count <= count - 3'h1;
					end
				end
				default: begin
					active <= 1'b0;
				end
			endcase
		end
	end
endmodule : pse_pulse
`default_nettype wire

// file: rtl/pse_port_strobe.sv
// pse_port_strobe.sv: third parallel port with read/write strobes and external memory cycle timing
// assumes cpu requests are one-cycle pulses synchronous to CLOCK and pins are synchronous inputs
`include "pse_defines.svh"
`default_nettype none
// Function
// R1 - strobe enable makes port accesses pulse strobes
// R2 - each port strobe lasts exactly two cycles
// R3 - write strobe two cycles after port update (the pin falls three cycles after PORT_OUT changes)
// R4 - read returns pins latched three cycles before strobe (the code latches them four cycles before READ_STROBE_N falls)
// R5 - read: wait three cycles, strobe two (the pin waits four cycles after the read, then strobes two)
// R6 - read strobe never samples the pins
// R7 - outside changes pins only after read strobe
// R8 - first pointer address only during strobes
// R9 - second pointer address whole access cycle
// R10 - program read window three clock periods
// R11 - data read window three or five periods
// R12 - strobes active low, idle high
module pse_port_strobe #(
	parameter int WIDTH = 8,
	parameter int AW    = 16
) (
	input  wire logic          CLOCK,          // 20 MHz clock
	input  wire logic          RSTN,           // async reset, active low
	input  wire logic          STROBE_ENABLE,  // port strobe enable control bit
	input  wire logic          PORT_WRITE,     // cpu writes the port, one-cycle pulse
	input  wire logic [WIDTH-1:0] PORT_WDATA,  // data for the port write
	input  wire logic          PORT_READ,      // cpu reads the port, one-cycle pulse
	input  wire logic [WIDTH-1:0] PORT_PINS,   // port pin levels
	input  wire logic          MEM_START,      // start an external memory access, pulse
	input  wire logic          MEM_PROGRAM,    // access is a program read
	input  wire logic          MEM_WRITE,      // access is a data write
	input  wire logic          MEM_LONG,       // long (stretched) data read
	input  wire logic          MEM_SECOND_PTR, // address from the second auto pointer
	input  wire logic [AW-1:0] MEM_ADDR,       // pointer address
	output logic [WIDTH-1:0]   PORT_OUT,       // port output value
	output logic [WIDTH-1:0]   PORT_RDATA,     // value returned to the cpu
	output logic               READ_STROBE_N,  // read strobe, active low
	output logic               WRITE_STROBE_N, // write strobe, active low
	output logic               PSEN_N,         // program read strobe, active low
	output logic [AW-1:0]      ADDR_OUT,       // external address bus
	output logic               ADDR_OE,        // address bus driven
	output logic               MEM_BUSY        // memory access under way
);
	// -----------------------------------------------------------------
	// port accesses
	// -----------------------------------------------------------------
	logic port_wr_act;
	logic port_rd_act;

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			PORT_OUT <= `PSE_PORT_RESET;
		end else if (PORT_WRITE) begin
			PORT_OUT <= PORT_WDATA;
		end
	end

	// the pins are captured at the read itself, which is four cycles ahead of the strobe pin
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			PORT_RDATA <= `PSE_PORT_RESET;
		end else if (PORT_READ) begin
			PORT_RDATA <= PORT_PINS; // R4 R6
		end
	end

	pse_pulse #(.DELAY_W(3)) u_wr_pulse (
		.clk     (CLOCK),
		.rst_n   (RSTN),
		.trigger (PORT_WRITE && STROBE_ENABLE), // R1
		.delay   (`PSE_WR_DELAY_CYCLES),        // R3
		.width   (`PSE_STROBE_CYCLES),          // R2
		.active  (port_wr_act)
	);

	pse_pulse #(.DELAY_W(3)) u_rd_pulse (
		.clk     (CLOCK),
		.rst_n   (RSTN),
		.trigger (PORT_READ && STROBE_ENABLE), // R1
		.delay   (`PSE_RD_DELAY_CYCLES),       // R5
		.width   (`PSE_STROBE_CYCLES),         // R2
		.active  (port_rd_act)
	);

	// -----------------------------------------------------------------
	// external memory cycles
	// -----------------------------------------------------------------
	pse_pkg::pse_mem_type mem_state;
	logic [2:0]           mem_count;
	logic                 mem_go;
	logic                 mem_prog;
	logic                 mem_wr;
	logic                 mem_ptr2;
	logic [AW-1:0]        mem_addr;

	function automatic logic [2:0] window(input logic prog, input logic lng);
		if (prog) begin
			window = `PSE_PMEM_WINDOW; // R10
		end else if (lng) begin
			window = `PSE_DMEM_LONG; // R11
		end else begin
			window = `PSE_DMEM_SHORT; // R11
		end
	endfunction : window

	// a start is honoured only once the busy pin is low, so a request on the
	// last busy cycle cannot slip in unseen by the outside
	always_comb begin
		mem_go = (mem_state == pse_pkg::PSE_MEM_IDLE) && MEM_START && !MEM_BUSY;
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			mem_state <= pse_pkg::PSE_MEM_IDLE;
		end else begin
			case (mem_state)
				pse_pkg::PSE_MEM_IDLE: begin
					if (mem_go) begin
						mem_state <= pse_pkg::PSE_MEM_ACTIVE;
					end
				end
				default: begin
					if (mem_count == 3'h0) begin
						mem_state <= pse_pkg::PSE_MEM_IDLE;
					end
				end
			endcase
		end
	end

	// the window counts down to zero and rests there while idle
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			mem_count <= 3'h0;
		end else if (mem_go) begin
			mem_count <= window(MEM_PROGRAM, MEM_LONG && !MEM_WRITE) - 3'h1; // R10 R11
		end else if (mem_count != 3'h0) begin
			mem_count <= mem_count - 3'h1;
		end
	end

	// access kind and address are held for the whole cycle
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			mem_prog <= 1'b0;
			mem_wr   <= 1'b0;
			mem_ptr2 <= 1'b0;
			mem_addr <= `PSE_ADDR_RESET;
		end else if (mem_go) begin
			mem_prog <= MEM_PROGRAM;
			mem_wr   <= MEM_WRITE && !MEM_PROGRAM;
			mem_ptr2 <= MEM_SECOND_PTR;
			mem_addr <= MEM_ADDR;
		end
	end

	// -----------------------------------------------------------------
	// pin outputs, all registered
	// -----------------------------------------------------------------
	logic next_mem_act;
	logic next_rd;
	logic next_wr;
	logic next_oe;

	always_comb begin
		next_mem_act = (mem_state == pse_pkg::PSE_MEM_ACTIVE);
		next_rd = port_rd_act || (next_mem_act && !mem_wr && !mem_prog);
		next_wr = port_wr_act || (next_mem_act && mem_wr);
		next_oe = next_mem_act && (mem_ptr2 || next_rd || next_wr); // R8 R9
	end

	// one helper for all three strobe pins keeps their polarity in one place
	function automatic logic strobe_level(input logic act);
		strobe_level = !act; // R12
	endfunction : strobe_level

	// outputs lag the internal state by one cycle; both strobe pins keep equal latency
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			READ_STROBE_N <= 1'b1; // R12
		end else begin
			READ_STROBE_N <= strobe_level(next_rd); // R12
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			WRITE_STROBE_N <= 1'b1; // R12
		end else begin
			WRITE_STROBE_N <= strobe_level(next_wr); // R12
		end
	end

	// program reads use their own strobe and never the data strobes
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			PSEN_N <= 1'b1;
		end else begin
			PSEN_N <= strobe_level(next_mem_act && mem_prog);
		end
	end

	// -----------------------------------------------------------------
	// address bus
	// -----------------------------------------------------------------
	// the first pointer drives the bus only with a strobe, the second for the whole access
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			ADDR_OUT <= `PSE_ADDR_RESET;
			ADDR_OE  <= 1'b0;
		end else begin
			ADDR_OUT <= next_oe ? mem_addr : `PSE_ADDR_RESET; // R8 R9
			ADDR_OE  <= next_oe; // R8 R9
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			MEM_BUSY <= 1'b0;
		end else begin
			MEM_BUSY <= next_mem_act;
		end
	end
endmodule : pse_port_strobe
`default_nettype wire

// file: verif/pse_checker.sv
// pse_checker.sv: assertions on the port strobe block
// assumes one clock domain; bound to every pse_port_strobe
`default_nettype none
module pse_checker #(
	parameter int WIDTH = 8,
	parameter int AW    = 16
) (
	input  wire logic             CLOCK,          // clock
	input  wire logic             RSTN,           // reset, active low
	input  wire logic             STROBE_ENABLE,  // port strobe enable
	input  wire logic             PORT_WRITE,     // cpu port write
	input  wire logic             PORT_READ,      // cpu port read
	input  wire logic             MEM_START,      // memory access start
	input  wire logic             MEM_PROGRAM,    // program read
	input  wire logic             MEM_WRITE,      // data write
	input  wire logic             MEM_LONG,       // long data read
	input  wire logic             MEM_SECOND_PTR, // second pointer
	input  wire logic [WIDTH-1:0] PORT_WDATA,     // byte written
	input  wire logic [WIDTH-1:0] PORT_PINS,      // pin levels
	input  wire logic [WIDTH-1:0] PORT_OUT,       // port output
	input  wire logic [WIDTH-1:0] PORT_RDATA,     // byte read
	input  wire logic [AW-1:0]    MEM_ADDR,       // pointer address
	input  wire logic [AW-1:0]    ADDR_OUT,       // address bus
	input  wire logic             READ_STROBE_N,  // read strobe, active low
	input  wire logic             WRITE_STROBE_N, // write strobe, active low
	input  wire logic             PSEN_N,         // program strobe, active low
	input  wire logic             ADDR_OE,        // address driven
	input  wire logic             MEM_BUSY        // access under way
);
	timeunit 1ns;
	timeprecision 1ns;
	wire logic go = MEM_START && !MEM_BUSY;
	wire logic rd = go && !MEM_WRITE && !MEM_PROGRAM;
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RSTN);
	a_write_timing: assert property (PORT_WRITE && STROBE_ENABLE |->
		##1 WRITE_STROBE_N [*3] ##1 !WRITE_STROBE_N [*2] ##1 WRITE_STROBE_N) else $error("write strobe timing");
	a_read_timing: assert property (PORT_READ && STROBE_ENABLE |->
		##1 READ_STROBE_N [*4] ##1 !READ_STROBE_N [*2] ##1 READ_STROBE_N) else $error("read strobe timing");
	a_strobe_off: assert property (!STROBE_ENABLE && (PORT_WRITE || PORT_READ) && !MEM_BUSY |->
		##1 (READ_STROBE_N && WRITE_STROBE_N) [*6]) else $error("strobe while disabled");
	a_read_capture: assert property (PORT_READ |=> PORT_RDATA == $past(PORT_PINS))
		else $error("read data not captured");
	a_no_sampling: assert property (!PORT_READ |=> $stable(PORT_RDATA))
		else $error("read data changed");
	a_ptr1_gated: assert property (ADDR_OE && !MEM_SECOND_PTR |-> !(READ_STROBE_N && WRITE_STROBE_N))
		else $error("first pointer address outside strobe");
	a_ptr2_held: assert property (go && MEM_SECOND_PTR |-> ##2 ADDR_OE [*3])
		else $error("second pointer address dropped");
	a_short_read: assert property (rd && !MEM_LONG |-> ##2 (!READ_STROBE_N && MEM_BUSY) [*3] ##1 READ_STROBE_N)
		else $error("short read window");
	a_long_read: assert property (rd && MEM_LONG |-> ##2 (!READ_STROBE_N && MEM_BUSY) [*5] ##1 READ_STROBE_N)
		else $error("long read window");
	a_prog_read: assert property (go && MEM_PROGRAM |-> ##2 !PSEN_N [*3] ##1 PSEN_N)
		else $error("program read window");
endmodule : pse_checker
bind pse_port_strobe pse_checker #(.WIDTH(WIDTH), .AW(AW)) chk_u (.*);
`default_nettype wire

// file: verif/pse_ext_model.sv
// pse_ext_model.sv: outside logic that offers and takes port bytes
// assumes active low strobes synchronous to clk
`default_nettype none
module pse_ext_model (
	input  wire logic       clk,      // clock
	input  wire logic       rst_n,    // reset, active low
	input  wire logic       rd_n,     // read strobe
	input  wire logic       wr_n,     // write strobe
	input  wire logic [7:0] port_out, // byte from the block
	output logic      [7:0] pins,     // byte offered
	output logic      [7:0] taken     // last byte taken
);
	timeunit 1ns;
	timeprecision 1ns;
	logic rd_q, wr_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{rd_q, wr_q, pins, taken} <= {2'h3, 8'h5a, 8'h00};
		end else begin
			{rd_q, wr_q} <= {rd_n, wr_n};
			if (rd_n && !rd_q) pins <= pins + 8'h01;
			if (wr_n && !wr_q) taken <= port_out;
		end
	end
endmodule : pse_ext_model
`default_nettype wire

// file: verif/pse_tb.sv
// pse_tb.sv: self-checking bench for the port strobe block
// assumes the block, checker and outside model compile first
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0, se = 1, pw = 0, pr = 0, ms = 0, mp = 0, mw = 0, ml = 0, m2 = 0;
	logic [7:0] wd = 8'h00, pins, pout, rdata, taken;
	logic [15:0] ma = 16'ha5c3, aout;
	logic rd_n, wr_n, ps_n, aoe, busy;
	int fail_count = 0, total_checks = 0;
	pse_port_strobe dut_u (.CLOCK(clk), .RSTN(rst_n), .STROBE_ENABLE(se), .PORT_WRITE(pw), .PORT_WDATA(wd),
		.PORT_READ(pr), .PORT_PINS(pins), .MEM_START(ms), .MEM_PROGRAM(mp), .MEM_WRITE(mw), .MEM_LONG(ml),
		.MEM_SECOND_PTR(m2), .MEM_ADDR(ma), .PORT_OUT(pout), .PORT_RDATA(rdata), .READ_STROBE_N(rd_n),
		.WRITE_STROBE_N(wr_n), .PSEN_N(ps_n), .ADDR_OUT(aout), .ADDR_OE(aoe), .MEM_BUSY(busy));
	pse_ext_model ext_u (.clk(clk), .rst_n(rst_n), .rd_n(rd_n), .wr_n(wr_n), .port_out(pout), .pins(pins),
		.taken(taken));
	initial begin
		forever #25 clk = ~clk;
	end
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic final_report;
		if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	task automatic t_write(input logic [7:0] v, input logic [7:0] exp);
		@(negedge clk);
		{wd, pw} = {v, 1'b1};
		@(negedge clk);
		pw = 0;
		check("port out", {8'h00, v}, {8'h00, pout});
		repeat (6) @(negedge clk);
		check("byte taken", {8'h00, exp}, {8'h00, taken});
	endtask : t_write
	task automatic t_read(input logic [7:0] step);
		logic [7:0] p;
		@(negedge clk);
		{p, pr} = {pins, 1'b1};
		@(negedge clk);
		pr = 0;
		repeat (7) @(negedge clk);
		check("read data", {8'h00, p}, {8'h00, rdata});
		check("next byte", {8'h00, p + step}, {8'h00, pins});
	endtask : t_read
	task automatic t_mem(input logic prog, wr, lng, sec, input int n);
		int cnt = 0;
		logic [3:0] pin_exp;
		// first pointer: address only with a data strobe; program reads use their own strobe
		pin_exp = {sec || !prog, prog || wr, prog || !wr, !prog};
		@(negedge clk);
		{mp, mw, ml, m2, ms} = {prog, wr, lng, sec, 1'b1};
		@(negedge clk);
		ms = 0;
		repeat (8) begin
			@(negedge clk);
			if (busy === 1'b1) cnt++;
			if (busy === 1'b1) check("address", (sec || !prog) ? ma : 16'h0000, aout);
			if (busy === 1'b1) check("mem strobes", {12'h000, pin_exp}, {12'h000, aoe, rd_n, wr_n, ps_n});
		end
		check("busy cycles", 16'(n), 16'(cnt));
	endtask : t_mem
	// run takes under 200 cycles; the limit allows twenty times that
	initial begin
		#200000;
		fail_count++;
		final_report;
	end
	initial begin
		repeat (12) @(negedge clk);
		rst_n = 1;
		check("idle strobes", 16'h0007, {13'h0000, rd_n, wr_n, ps_n});
		t_write(8'hc3, 8'hc3);
		t_write(8'h3c, 8'h3c);
		t_read(8'h01);
		t_read(8'h01);
		se = 0;
		t_write(8'h99, 8'h3c);
		t_read(8'h00);
		se = 1;
		t_mem(1'b0, 1'b0, 1'b0, 1'b0, 3);
		t_mem(1'b0, 1'b0, 1'b1, 1'b1, 5);
		t_mem(1'b1, 1'b0, 1'b0, 1'b1, 3);
		t_mem(1'b0, 1'b1, 1'b0, 1'b0, 3);
		t_mem(1'b1, 1'b0, 1'b0, 1'b0, 3);
		t_mem(1'b0, 1'b1, 1'b1, 1'b1, 3);
		check("idle strobes", 16'h0007, {13'h0000, rd_n, wr_n, ps_n});
		final_report;
	end
endmodule : testbench
`default_nettype wire
